// ---- logic/prm_pkg.sv ----
// Constants, field layouts and types shared by the pin remap matrix.
`default_nettype none

package prm_pkg;

  // Pin and function counts.
  localparam int unsigned NUM_FULL = 2;
  localparam int unsigned NUM_PINS = 4;
  localparam int unsigned NUM_FUNC = 4;
  localparam int unsigned NUM_PIN_IN = 4;

  // Field widths.
  localparam int unsigned FUNC_W = 6;
  localparam int unsigned SEL_W = 7;
  localparam int unsigned AW = 8;
  localparam int unsigned DW = 32;

  // Remappable pin numbers: two full pins first, then two input-only pins.
  localparam logic [SEL_W-1:0] PIN_NUM [NUM_PINS] = '{7'h76, 7'h78, 7'h20, 7'h21};
  localparam logic [SEL_W-1:0] PIN_NONE = 7'h00;
  localparam logic [FUNC_W-1:0] FUNC_NONE = 6'h00;
  localparam logic [FUNC_W-1:0] FUNC_MAX = 6'h04;

  // Register byte offsets.
  localparam logic [AW-1:0] A_OUT8 = 8'h00;
  localparam logic [AW-1:0] A_OUT9 = 8'h04;
  localparam logic [AW-1:0] A_IN0 = 8'h08;
  localparam logic [AW-1:0] A_IN1 = 8'h0c;
  localparam logic [AW-1:0] A_LOCK = 8'h10;
  localparam logic [AW-1:0] A_KEY = 8'h14;
  localparam logic [AW-1:0] A_STAT = 8'h18;

  // Field positions.
  localparam int unsigned OUT8_LSB = 8;
  localparam int unsigned OUT9_LSB = 0;
  localparam int unsigned SEL_LO_LSB = 0;
  localparam int unsigned SEL_HI_LSB = 8;
  localparam int unsigned LOCK_BIT = 0;
  localparam int unsigned STAT_LVL_LSB = 0;
  localparam int unsigned STAT_LOCK_BIT = 8;
  localparam int unsigned STAT_OPEN_BIT = 9;

  // Values after reset.
  localparam logic [FUNC_W-1:0] RST_FUNC = 6'h00;
  localparam logic [SEL_W-1:0] RST_SEL = 7'h00;
  localparam logic RST_LOCK = 1'b0;

  // Unlock key sequence.
  localparam logic [15:0] UNLOCK_KEY1 = 16'h0055;
  localparam logic [15:0] UNLOCK_KEY2 = 16'h00aa;

  // Level and output enable of one pad driver.
  typedef struct packed {
    logic lvl;
    logic oe;
  } prm_pad_t;

  // Unlock sequence states.
  typedef enum logic [1:0] {
    KEY_IDLE,
    KEY_HALF,
    KEY_OPEN
  } prm_key_t;

endpackage

`default_nettype wire

// ---- logic/prm_pin_remap.sv ----
// Pin remap matrix with APB register access.
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none

module prm_pin_remap import prm_pkg::*; (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_b,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [DW-1:0] pwdata,
  output logic [DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pads.
  input wire logic [NUM_PINS-1:0] pad_in,
  input wire logic [NUM_PINS-1:0] pin_analog,
  output prm_pad_t [NUM_FULL-1:0] pad_drv,
  // Port latch and dedicated peripheral drive per full pin.
  input wire prm_pad_t [NUM_FULL-1:0] gpio_drv,
  input wire prm_pad_t [NUM_FULL-1:0] fixed_drv,
  // Remappable peripherals.
  input wire logic [NUM_FUNC-1:0] periph_out,
  output logic [NUM_PIN_IN-1:0] periph_in,
  // Status.
  output logic map_locked
);

  logic rst_s1_q;
  logic rst_n_q;
  logic [NUM_PINS-1:0] sync1_q;
  logic [NUM_PINS-1:0] sync2_q;
  logic [FUNC_W-1:0] func_q [NUM_FULL];
  logic [SEL_W-1:0] sel_q [NUM_PIN_IN];
  logic lock_q;
  prm_key_t key_q;
  logic [DW-1:0] prdata_q;
  logic [DW-1:0] rdata_d;
  logic pready_q;
  logic pslverr_q;
  logic err_d;
  prm_pad_t [NUM_FULL-1:0] pad_q;
  prm_pad_t [NUM_FULL-1:0] pad_d;
  logic [NUM_PIN_IN-1:0] periph_in_q;
  logic [NUM_PIN_IN-1:0] periph_in_d;
  logic [NUM_PIN_IN-1:0] sel_hit;
  logic setup;
  logic fire;
  logic wr_fire;
  logic is_map;

  // Reset release through two flip-flops.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  assign setup = psel & ~penable;
  assign fire = psel & penable & pready_q;
  assign wr_fire = fire & pwrite;
  assign is_map = (paddr == A_OUT8) || (paddr == A_OUT9) || (paddr == A_IN0) || (paddr == A_IN1);

  // Read data and error are prepared in the setup cycle.
  always_comb begin
    rdata_d = '0;
    err_d = 1'b0;
    if (paddr == A_OUT8) begin
      rdata_d[OUT8_LSB +: FUNC_W] = func_q[0];
    end else if (paddr == A_OUT9) begin
      rdata_d[OUT9_LSB +: FUNC_W] = func_q[1];
    end else if (paddr == A_IN0) begin
      rdata_d[SEL_LO_LSB +: SEL_W] = sel_q[0];
      rdata_d[SEL_HI_LSB +: SEL_W] = sel_q[1];
    end else if (paddr == A_IN1) begin
      rdata_d[SEL_LO_LSB +: SEL_W] = sel_q[2];
      rdata_d[SEL_HI_LSB +: SEL_W] = sel_q[3];
    end else if (paddr == A_LOCK) begin
      rdata_d[LOCK_BIT] = lock_q;
      if (pwrite && !pwdata[LOCK_BIT] && (key_q != KEY_OPEN)) begin
        err_d = 1'b1;
      end
    end else if (paddr == A_KEY) begin
      rdata_d = '0;
    end else if (paddr == A_STAT) begin
      rdata_d[STAT_LVL_LSB +: NUM_PINS] = sync2_q;
      rdata_d[STAT_LOCK_BIT] = lock_q;
      rdata_d[STAT_OPEN_BIT] = (key_q == KEY_OPEN);
    end else begin
      err_d = 1'b1;
    end
    if (pwrite && lock_q && is_map) begin
      err_d = 1'b1;
    end
  end

  // Bus answer: one access cycle, no wait states.
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & err_d;
      prdata_q <= (setup && !pwrite) ? rdata_d : '0;
    end
  end

  // Output and input select registers, frozen while locked.
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      func_q[0] <= RST_FUNC;
      func_q[1] <= RST_FUNC;
      for (int i = 0; i < NUM_PIN_IN; i++) begin
        sel_q[i] <= RST_SEL;
      end
    end else if (wr_fire && !lock_q) begin
      if (paddr == A_OUT8) begin
        func_q[0] <= pwdata[OUT8_LSB +: FUNC_W];
      end else if (paddr == A_OUT9) begin
        func_q[1] <= pwdata[OUT9_LSB +: FUNC_W];
      end else if (paddr == A_IN0) begin
        sel_q[0] <= pwdata[SEL_LO_LSB +: SEL_W];
        sel_q[1] <= pwdata[SEL_HI_LSB +: SEL_W];
      end else if (paddr == A_IN1) begin
        sel_q[2] <= pwdata[SEL_LO_LSB +: SEL_W];
        sel_q[3] <= pwdata[SEL_HI_LSB +: SEL_W];
      end
    end
  end

  // Unlock key sequence; any other write drops it.
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      key_q <= KEY_IDLE;
    end else if (wr_fire) begin
      if (paddr == A_KEY) begin
        case (key_q)
          KEY_HALF: begin
            key_q <= (pwdata[15:0] == UNLOCK_KEY2) ? KEY_OPEN : KEY_IDLE;
          end
          default: begin
            key_q <= (pwdata[15:0] == UNLOCK_KEY1) ? KEY_HALF : KEY_IDLE;
          end
        endcase
      end else begin
        key_q <= KEY_IDLE;
      end
    end
  end

  // Lock sets at any time and clears only with the key open.
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      lock_q <= RST_LOCK;
    end else if (wr_fire && (paddr == A_LOCK)) begin
      if (pwdata[LOCK_BIT]) begin
        lock_q <= 1'b1;
      end else if (key_q == KEY_OPEN) begin
        lock_q <= 1'b0;
      end
    end
  end

  // Pad input synchroniser.
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pad_in;
      sync2_q <= sync1_q;
    end
  end

  // Input routing: each peripheral input follows the selected pin.
  always_comb begin
    periph_in_d = '0;
    sel_hit = '0;
    for (int i = 0; i < NUM_PIN_IN; i++) begin
      for (int p = 0; p < NUM_PINS; p++) begin
        if (sel_q[i] == PIN_NUM[p]) begin
          sel_hit[i] = 1'b1;
          periph_in_d[i] = sync2_q[p] & ~pin_analog[p];
        end
      end
    end
  end

  // Output priority per full pin: analog, remap, dedicated, port.
  always_comb begin
    pad_d = '0;
    for (int k = 0; k < NUM_FULL; k++) begin
      if (pin_analog[k]) begin
        pad_d[k] = '0;
      end else if ((func_q[k] != FUNC_NONE) && (func_q[k] <= FUNC_MAX)) begin
        pad_d[k].lvl = periph_out[2'(func_q[k] - 6'h01)];
        pad_d[k].oe = 1'b1;
      end else if (fixed_drv[k].oe) begin
        pad_d[k] = fixed_drv[k];
      end else begin
        pad_d[k] = gpio_drv[k];
      end
    end
  end

  // Input-only pins have no driver, so they can never be outputs.
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pad_q <= '0;
      periph_in_q <= '0;
    end else begin
      pad_q <= pad_d;
      periph_in_q <= periph_in_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pad_drv = pad_q;
  assign periph_in = periph_in_q;
  assign map_locked = lock_q;

  // Checks on the routing and the register file.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n_q);

  AST_IN_OUT_SEPARATE: assert property (
    wr_fire && (paddr == A_IN0) |=> $stable(func_q[0]) && $stable(func_q[1]))
    else $error("Input select write changed an output select.");

  AST_UNLISTED_PIN_LOW: assert property (
    !sel_hit[0] |=> !periph_in_q[0])
    else $error("Unlisted pin number reached a peripheral input.");

  AST_LOCK_REFUSES: assert property (
    lock_q && setup && pwrite && (paddr == A_OUT8) |=> pslverr_q ##1 $stable(func_q[0]))
    else $error("Locked map accepted a write.");

  AST_UNLOCK_NEEDS_KEY: assert property (
    $fell(lock_q) |-> $past(key_q) == KEY_OPEN)
    else $error("Lock cleared without the key sequence.");

  AST_INONLY_ROUTES: assert property (
    (sel_q[1] == PIN_NUM[2] && !pin_analog[2])[*3] |-> periph_in_q[1] == $past(pad_in[2], 3))
    else $error("Input-only pin not routed to its peripheral input.");

  AST_NO_DEFAULT_PIN: assert property (
    $rose(rst_n_q) |-> func_q[0] == FUNC_NONE && func_q[1] == FUNC_NONE && sel_q[0] == PIN_NONE)
    else $error("Remappable signal has a pin after reset.");

  AST_FIXED_DEFAULT: assert property (
    func_q[0] == FUNC_NONE && !pin_analog[0] && fixed_drv[0].oe |=> pad_q[0] == $past(fixed_drv[0]))
    else $error("Dedicated peripheral lost its default pin.");

  AST_REMAP_WINS: assert property (
    func_q[0] == 6'h02 && !pin_analog[0] |=> pad_q[0].oe && pad_q[0].lvl == $past(periph_out[1]))
    else $error("Remapped output did not take the pin.");

  AST_ANALOG_WINS: assert property (
    pin_analog[0] |=> pad_q[0] == '0)
    else $error("Remap drove a pin in analog use.");

  AST_OUT8_LAYOUT: assert property (
    fire && !pwrite && (paddr == A_OUT8) |-> prdata_q[13:8] == func_q[0]
      && prdata_q[31:14] == '0 && prdata_q[7:0] == '0)
    else $error("Pin 118 select read back wrong.");

  AST_OUT9_LAYOUT: assert property (
    fire && !pwrite && (paddr == A_OUT9) |-> prdata_q[5:0] == func_q[1] && prdata_q[31:6] == '0)
    else $error("Pin 120 select read back wrong.");

  AST_CODE_ZERO_PORT: assert property (
    func_q[0] == FUNC_NONE && !pin_analog[0] && !fixed_drv[0].oe |=> pad_q[0] == $past(gpio_drv[0]))
    else $error("Code zero did not leave the pin to the port.");

  AST_IN_ROUTE: assert property (
    (sel_q[0] == PIN_NUM[0] && !pin_analog[0])[*3] |-> periph_in_q[0] == $past(pad_in[0], 3))
    else $error("Peripheral input does not follow the selected pin.");

  AST_ANALOG_INPUT_ZERO: assert property (
    sel_q[1] == PIN_NUM[2] && pin_analog[2] |=> !periph_in_q[1])
    else $error("Analog pin reached a peripheral input.");

  AST_UNLISTED_SEL3_LOW: assert property (
    !sel_hit[3] |=> !periph_in_q[3])
    else $error("Unlisted pin number reached input three.");

  AST_LOCKED_SEL_KEPT: assert property (
    lock_q && wr_fire && (paddr == A_IN0) |=> $stable(sel_q[0]) && $stable(sel_q[1]))
    else $error("Locked map accepted an input select write.");

  AST_KEY_SINGLE_USE: assert property (
    $fell(lock_q) |-> key_q == KEY_IDLE)
    else $error("Unlock key stayed open after use.");

  AST_REMAP_WINS_HI: assert property (
    func_q[1] == 6'h04 && !pin_analog[1] |=> pad_q[1].oe && pad_q[1].lvl == $past(periph_out[3]))
    else $error("Remapped output did not take pin 120.");

  AST_BAD_CODE_PORT: assert property (
    func_q[1] > FUNC_MAX && !pin_analog[1] && !fixed_drv[1].oe
      |=> pad_q[1] == $past(gpio_drv[1]))
    else $error("Unused code did not leave the pin to the port.");

  AST_IN1_LAYOUT: assert property (
    fire && !pwrite && (paddr == A_IN1) |-> prdata_q[6:0] == sel_q[2]
      && prdata_q[14:8] == sel_q[3] && prdata_q[7] == 1'b0 && prdata_q[31:15] == '0)
    else $error("Input select pair read back wrong.");

  COV_REMAP_OUT: cover property (func_q[0] != FUNC_NONE && pad_q[0].oe);
  COV_UNLOCK: cover property ($fell(lock_q));
  COV_LOCKED_ERR: cover property (fire && pslverr_q && lock_q);
  COV_ANALOG_OVERRIDE: cover property (pin_analog[0] && func_q[0] != FUNC_NONE);
  COV_INPUT_ROUTED: cover property (sel_hit[2] && periph_in_q[2]);

endmodule // prm_pin_remap

`default_nettype wire

// ---- testbench/prm_far_model.sv ----
// Far side model: pads, port latches and dedicated and remappable peripherals.
`timescale 1ns/1ps
`default_nettype none
module prm_far_model import prm_pkg::*; (
  // Scenario controls.
  input wire logic [NUM_PINS-1:0] lvl,
  input wire logic [NUM_PINS-1:0] ana,
  input wire logic [NUM_FULL-1:0] fx_oe,
  input wire logic [NUM_FUNC-1:0] fn,
  // Toward the matrix.
  output logic [NUM_PINS-1:0] pad_in,
  output logic [NUM_PINS-1:0] pin_analog,
  output prm_pad_t [NUM_FULL-1:0] gpio_drv,
  output prm_pad_t [NUM_FULL-1:0] fixed_drv,
  output logic [NUM_FUNC-1:0] periph_out
);
  // Port latches drive low, dedicated peripherals drive high.
  always_comb begin
    pad_in = lvl;
    pin_analog = ana;
    periph_out = fn;
    for (int i = 0; i < NUM_FULL; i++) begin
      gpio_drv[i] = '{lvl: 1'b0, oe: 1'b1};
      fixed_drv[i] = '{lvl: 1'b1, oe: fx_oe[i]};
    end
  end
endmodule // prm_far_model
`default_nettype wire

// ---- testbench/tb.sv ----
// Self-checking bench for the pin remap matrix.
`timescale 1ns/1ps
`default_nettype none
module tb import prm_pkg::*;;
  logic sys_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
  logic [AW-1:0] paddr = '0;
  logic [DW-1:0] pwdata = '0, prdata, rdata;
  logic pready, pslverr, map_locked, rerr;
  logic [NUM_PINS-1:0] lvl = '0, ana = '0, pad_in, pin_analog;
  logic [NUM_FULL-1:0] fx_oe = '0;
  logic [NUM_FUNC-1:0] fn = '0, periph_out;
  logic [NUM_PIN_IN-1:0] periph_in;
  prm_pad_t [NUM_FULL-1:0] pad_drv, gpio_drv, fixed_drv;
  int miscompares = 0, compares = 0, cycles = 0;

  always #12.5 sys_clk = ~sys_clk;

  prm_pin_remap i_prm_pin_remap (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_in(pad_in),
    .pin_analog(pin_analog), .pad_drv(pad_drv), .gpio_drv(gpio_drv),
    .fixed_drv(fixed_drv), .periph_out(periph_out), .periph_in(periph_in),
    .map_locked(map_locked));

  prm_far_model i_prm_far_model (.lvl(lvl), .ana(ana), .fx_oe(fx_oe), .fn(fn),
    .pad_in(pad_in), .pin_analog(pin_analog), .gpio_drv(gpio_drv),
    .fixed_drv(fixed_drv), .periph_out(periph_out));

  task automatic conclude;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; waits for pready and leaves one idle cycle after it.
  task automatic xfer(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rdc(input logic [AW-1:0] a, input logic [DW-1:0] exp);
    xfer(1'b0, a, '0);
    chk(rdata, exp);
  endtask

  task automatic pad_chk(input logic [3:0] exp);
    repeat (2) @(posedge sys_clk);
    #1 chk(DW'(pad_drv), DW'(exp));
    @(posedge sys_clk);
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      conclude();
    end
  end

  initial begin
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rdc(A_OUT8, '0);
    rdc(A_OUT9, '0);
    xfer(1'b1, A_OUT8, '1);
    rdc(A_OUT8, 32'h3f00);
    xfer(1'b1, A_OUT9, '1);
    rdc(A_OUT9, 32'h3f);
    pad_chk(4'h5);
    $display("test 1 done");
    for (int c = 1; c <= 4; c++) begin
      fn <= NUM_FUNC'(1 << (c - 1));
      xfer(1'b1, A_OUT8, DW'(c) << OUT8_LSB);
      xfer(1'b1, A_OUT9, DW'(c));
      pad_chk(4'hf);
    end
    fx_oe <= 2'b11;
    fn <= '0;
    pad_chk(4'h5);
    ana <= 4'h1;
    pad_chk(4'h4);
    ana <= '0;
    xfer(1'b1, A_OUT8, '0);
    xfer(1'b1, A_OUT9, '0);
    pad_chk(4'hf);
    fx_oe <= '0;
    pad_chk(4'h5);
    $display("test 2 done");
    xfer(1'b1, A_IN0, 32'h2076);
    xfer(1'b1, A_IN1, 32'h7778);
    rdc(A_OUT8, '0);
    rdc(A_IN1, 32'h7778);
    lvl <= 4'hf;
    repeat (2) @(posedge sys_clk);
    #1 chk(DW'(periph_in), 32'h0);
    @(posedge sys_clk);
    #1 chk(DW'(periph_in), 32'h7);
    @(posedge sys_clk);
    ana <= 4'h4;
    repeat (4) @(posedge sys_clk);
    #1 chk(DW'(periph_in), 32'h5);
    @(posedge sys_clk);
    ana <= '0;
    $display("test 3 done");
    xfer(1'b1, A_LOCK, 32'h1);
    chk(DW'(map_locked), 32'h1);
    xfer(1'b1, A_OUT8, 32'h100);
    chk(DW'(rerr), 32'h1);
    rdc(A_OUT8, '0);
    xfer(1'b1, A_IN0, 32'h0);
    chk(DW'(rerr), 32'h1);
    rdc(A_IN0, 32'h2076);
    xfer(1'b1, A_LOCK, 32'h0);
    chk(DW'(rerr), 32'h1);
    xfer(1'b1, A_KEY, 32'h55);
    xfer(1'b1, A_KEY, 32'haa);
    rdc(A_STAT, 32'h30f);
    xfer(1'b1, A_LOCK, 32'h0);
    chk(DW'(map_locked), 32'h0);
    chk(DW'(rerr), 32'h0);
    xfer(1'b1, A_OUT8, 32'h100);
    rdc(A_OUT8, 32'h100);
    rdc(8'h1c, '0);
    chk(DW'(rerr), 32'h1);
    $display("test 4 done");
    conclude();
  end
endmodule // tb
`default_nettype wire
